// File: dv/bcr_host.sv
// bcr_host: host-side model that issues register reads and writes
// assumes: one shared clock, slave answers reads in the next cycle
`timescale 1ns/1ps
`default_nettype none

module bcr_host (
    // clock
    input  wire logic        clock,
    // register port
    output var  logic [11:0] reg_addr,
    output var  logic [31:0] reg_wdata,
    output var  logic        reg_wr,
    output var  logic        reg_rd,
    input  wire logic [31:0] reg_rdata
);
    // ------------------------------------------------------------------
    // bus idle at time zero
    // ------------------------------------------------------------------
    initial begin
        reg_addr  = 12'h000;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // one-cycle write; released lines flip so stale values never look valid
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    // one-cycle read; data taken once it has settled in the following cycle
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule // bcr_host

`default_nettype wire

// File: dv/testbench.sv
// testbench: directed scenarios for the bootstrap control register bank
// assumes: bcr_pkg compiled first, host model drives the register port
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import bcr_pkg::*;
    logic        clock = 1'b0;     // 40 MHz
    logic        rstn = 1'b0;      // synchronous, active low
    logic [15:0] cap = 16'h120E;   // privilege, channel, time, map, multi
    logic        cmd_start = 1'b0; // command execution markers
    logic        cmd_done = 1'b0;
    logic        clk_en = 1'b1;    // low freezes all state
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, chan;
    logic        reg_wr, reg_rd, pend, hb_exp, link_def, priv_clr, multi_en, msg_ok;
    int          miscompares = 0, n_checks = 0, cyc = 0, hb_cnt = 0;

    always #12.5 clock = ~clock;

    // short millisecond tick keeps heartbeat runs to tens of cycles
    bcr_regs #(.MS_TICK(4)) u_dut (.clock(clock), .rstn(rstn), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .capability(cap), .cmd_start(cmd_start), .cmd_done(cmd_done),
        .pending_ack(pend), .hb_expired(hb_exp), .link_defaults(link_def),
        .priv_clear(priv_clr), .multi_event_en(multi_en), .msg_channel_number(chan),
        .msg_allowed(msg_ok));
    bcr_host u_host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        u_host.rd(a, d);
        chk({32'h0, d}, {32'h0, exp});
    endtask

    // watchdog: whole run needs well under a few thousand cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (hb_exp === 1'b1) begin
            hb_cnt <= hb_cnt + 1;
        end
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rdchk(OFS_HB_TIMEOUT, 32'h0000_0BB8);
        rdchk(OFS_MSG_CHANNEL, 32'h0);
        rdchk(OFS_DEV_CFG_LO, 32'h0);
        rdchk(OFS_TIME_LO, 32'h0);
        chk(msg_ok, 1'b0);
        $display("test reset done");
    endtask

    // clock enable low holds every register, a host write included
    task automatic t_freeze;
        @(posedge clock);
        clk_en <= 1'b0;
        u_host.wr(OFS_MSG_CHANNEL, 32'h0000_0009);
        clk_en <= 1'b1;
        rdchk(OFS_MSG_CHANNEL, 32'h0);
        chk(msg_ok, 1'b0);
        $display("test freeze done");
    endtask

    // read-only words keep their value when written; unmapped reads zero
    task automatic t_ro;
        u_host.wr(OFS_MAX_RESP_TIME, 32'h0000_0005);
        rdchk(OFS_MAX_RESP_TIME, 32'h0000_0064);
        u_host.wr(OFS_MANIFEST_LO, 32'hFFFF_FFFF);
        rdchk(OFS_MANIFEST_LO, 32'h0000_1000);
        rdchk(OFS_MANIFEST_HI, 32'h0);
        rdchk(OFS_TECH_MAP_LO, 32'h0000_2000);
        rdchk(12'h100, 32'h0);
        $display("test ro done");
    endtask

    // reserved configuration bits stay clear
    task automatic t_cfg;
        u_host.wr(OFS_DEV_CFG_LO, 32'hFFFF_FFFF);
        rdchk(OFS_DEV_CFG_LO, 32'h0000_0003);
        rdchk(OFS_DEV_CFG_HI, 32'h0);
        chk(multi_en, 1'b1);
        u_host.wr(OFS_DEV_CFG_LO, 32'h0);
        $display("test cfg done");
    endtask

    task automatic t_chan;
        u_host.wr(OFS_MSG_CHANNEL, 32'h0000_0005);
        rdchk(OFS_MSG_CHANNEL, 32'h0000_0005);
        chk({chan, msg_ok}, {32'h5, 1'b1});
        u_host.wr(OFS_MSG_CHANNEL, 32'h0);
        @(posedge clock);
        #1;
        chk(msg_ok, 1'b0);
        $display("test chan done");
    endtask

    // two latches six cycles apart differ by six clock periods in ns
    task automatic t_time;
        logic [31:0] lo1, hi1, lo2, hi2;
        u_host.wr(OFS_TIME_LATCH, 32'h1);
        u_host.rd(OFS_TIME_LO, lo1);
        u_host.rd(OFS_TIME_HI, hi1);
        u_host.wr(OFS_TIME_LATCH, 32'h1);
        u_host.rd(OFS_TIME_LO, lo2);
        u_host.rd(OFS_TIME_HI, hi2);
        chk({hi2, lo2}, {hi1, lo1} + 64'h6 * NS_PER_CLK);
        rdchk(OFS_TIME_LATCH, 32'h0);
        $display("test time done");
    endtask

    // accesses hold off expiry; silence of two ticks lets it fire
    task automatic t_hb;
        int i;
        int h0;
        logic [31:0] d;
        u_host.wr(OFS_HB_TIMEOUT, 32'h2);
        rdchk(OFS_HB_TIMEOUT, 32'h2);
        u_host.wr(OFS_DEV_CFG_LO, 32'h1);
        h0 = hb_cnt;
        repeat (8) u_host.rd(OFS_MAX_RESP_TIME, d);
        chk(hb_cnt, h0);
        for (i = 0; i < 20; i++) begin
            @(posedge clock);
            #1;
            if (hb_exp === 1'b1) break;
        end
        chk(i >= 4 && i <= 7, 1'b1);
        @(posedge clock);
        #1;
        chk({link_def, priv_clr}, 2'b11);
        u_host.wr(OFS_DEV_CFG_LO, 32'h0);
        h0 = hb_cnt;
        repeat (40) @(posedge clock);
        chk(hb_cnt, h0);
        $display("test hb done");
    endtask

    // pending ack arrives before 100 ms of 4-cycle ticks has passed
    task automatic t_pend;
        int i;
        cmd_start <= 1'b1;
        @(posedge clock);
        cmd_start <= 1'b0;
        for (i = 0; i < 400; i++) begin
            @(posedge clock);
            #1;
            if (pend === 1'b1) break;
        end
        chk(i < 400, 1'b1);
        cmd_done <= 1'b1;
        @(posedge clock);
        cmd_done <= 1'b0;
        $display("test pend done");
    endtask

    // without capabilities the optional registers vanish
    task automatic t_nocap;
        cap  <= 16'h0;
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        u_host.wr(OFS_DEV_CFG_LO, 32'hFFFF_FFFF);
        rdchk(OFS_DEV_CFG_LO, 32'h0);
        u_host.wr(OFS_MSG_CHANNEL, 32'h7);
        rdchk(OFS_MSG_CHANNEL, 32'h0);
        chk(msg_ok, 1'b0);
        rdchk(OFS_HB_TIMEOUT, 32'h0);
        rdchk(OFS_TECH_MAP_LO, 32'h0);
        $display("test nocap done");
    endtask

    initial begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        t_reset();
        t_freeze();
        t_ro();
        t_cfg();
        t_chan();
        t_time();
        t_hb();
        t_pend();
        t_nocap();
        print_verdict();
    end
endmodule // testbench

`default_nettype wire

// File: logic/bcr_pkg.sv
// bcr_pkg: register map, field positions, reset values and timing constants
// for the bootstrap control register bank; assumes a 40 MHz device clock.
package bcr_pkg;

    // ------------------------------------------------------------------
    // register byte offsets (32-bit word bus, 64-bit values span two words)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_MAX_RESP_TIME  = 12'h1CC;
    localparam logic [11:0] OFS_MANIFEST_LO    = 12'h1D0;
    localparam logic [11:0] OFS_MANIFEST_HI    = 12'h1D4;
    localparam logic [11:0] OFS_TECH_MAP_LO    = 12'h1D8;
    localparam logic [11:0] OFS_TECH_MAP_HI    = 12'h1DC;
    localparam logic [11:0] OFS_DEV_CFG_LO     = 12'h1E0;
    localparam logic [11:0] OFS_DEV_CFG_HI     = 12'h1E4;
    localparam logic [11:0] OFS_HB_TIMEOUT     = 12'h1E8;
    localparam logic [11:0] OFS_MSG_CHANNEL    = 12'h1EC;
    localparam logic [11:0] OFS_TIME_LO        = 12'h1F0;
    localparam logic [11:0] OFS_TIME_HI        = 12'h1F4;
    localparam logic [11:0] OFS_TIME_LATCH     = 12'h1F8;

    // ------------------------------------------------------------------
    // capability bit positions (capability word is an input of the bank)
    // ------------------------------------------------------------------
    localparam int CAP_ACCESS_PRIV  = 1;
    localparam int CAP_MSG_CHANNEL  = 2;
    localparam int CAP_TIMESTAMP    = 3;
    localparam int CAP_TECH_MAP     = 9;
    localparam int CAP_MULTI_EVENT  = 12;

    // configuration and latch field positions
    localparam int CFG_HB_ENABLE    = 0;
    localparam int CFG_MULTI_EVENT  = 1;
    localparam int LATCH_BIT        = 0;

    // ------------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------------
    localparam logic [31:0] HB_TIMEOUT_RST     = 32'h0000_0BB8;  // 3000 ms
    localparam logic [31:0] MSG_CHANNEL_RST    = 32'h0000_0000;
    localparam logic [63:0] TIME_RST           = 64'h0;
    localparam logic [31:0] MAX_RESP_LIMIT_MS  = 32'h0000_012C;  // 300 ms
    localparam logic [31:0] READ_LIMIT_MS      = 32'h0000_0032;  // 50 ms
    localparam logic [31:0] ZERO32             = 32'h0;
    localparam logic [7:0]  PRIV_AVAILABLE     = 8'h00;

    // ------------------------------------------------------------------
    // timing: 1 ms tick and nanosecond step per clock
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS    = 25000;
    localparam int MS_IN_PS         = 1000000000;
    localparam int MS_CYCLES        = MS_IN_PS / CLK_PERIOD_PS;   // 40000
    localparam logic [63:0] NS_PER_CLK = 64'(CLK_PERIOD_PS / 1000);

    // register access request carried as one bundle
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } bcr_req_s;

endpackage

// File: logic/bcr_regs.sv
// bcr_regs: bootstrap control register bank with heartbeat, message
// channel and nanosecond timestamp; registers are reached over a plain
// strobe port, read data one cycle after the read strobe.
// assumes: synchronous inputs, capability word stable, clk at 40 MHz.
// limitation: stored bits are not re-checked against capability, so a
// capability dropped at run time needs a reset to clear what was set.
//
// Operation
// - pending ack raised before response time elapses
// - advertised response time capped at 300 ms
// - response time read answered next cycle
// - read-only response time word at 0x1CC
// - read-only manifest pointer at 0x1D0
// - tech map pointer only with capability
// - heartbeat enable bit needs privilege capability
// - multi-event bit needs capability, rest zero
// - heartbeat timeout only with privilege capability
// - heartbeat expiry restores link defaults
// - any host access restarts heartbeat
// - heartbeat timeout 32-bit, default 3000 ms
// - message channel number resets to zero
// - zero channel number blocks messages
// - channel register only with capability
// - time register returns last captured count
// - time register resets zero, needs capability
// - expiry returns privilege state to available
// - latch write captures counter, self-clearing
// - privilege capability gates heartbeat registers
`timescale 1ns/1ps
`default_nettype none

module bcr_regs
    import bcr_pkg::*;
#(
    parameter logic [31:0] MAX_RESP_MS  = 32'h0000_0064,     // advertised limit, default 100 ms
    parameter logic [63:0] MANIFEST_PTR = 64'h0000_0000_0000_1000,
    parameter logic [63:0] TECH_MAP_PTR = 64'h0000_0000_0000_2000,
    parameter int          MS_TICK      = MS_CYCLES          // shorten in simulation
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        clk_en,
    // register port
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [31:0] reg_rdata,
    // unit side
    input  wire logic [15:0] capability,
    input  wire logic        cmd_start,
    input  wire logic        cmd_done,
    output var  logic        pending_ack,
    output var  logic        hb_expired,
    output var  logic        link_defaults,
    output var  logic        priv_clear,
    output var  logic        multi_event_en,
    output var  logic [31:0] msg_channel_number,
    output var  logic        msg_allowed
);

    // ------------------------------------------------------------------
    // request bundle and capability flags
    // ------------------------------------------------------------------
    bcr_req_s req;                                    // bundled bus request
    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    logic cap_priv;                                   // heartbeat/privilege support
    logic cap_msg;                                    // message channel support
    logic cap_ts;                                     // timestamp support
    logic cap_tech;                                   // tech map support
    logic cap_multi;                                  // multi-event support
    assign cap_priv  = capability[CAP_ACCESS_PRIV];
    assign cap_msg   = capability[CAP_MSG_CHANNEL];
    assign cap_ts    = capability[CAP_TIMESTAMP];
    assign cap_tech  = capability[CAP_TECH_MAP];
    assign cap_multi = capability[CAP_MULTI_EVENT];

    // address match, used by both the write and read paths
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    // advertised response time, never above the cap
    logic [31:0] max_resp;
    assign max_resp = (MAX_RESP_MS > MAX_RESP_LIMIT_MS) ? MAX_RESP_LIMIT_MS : MAX_RESP_MS;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic        hb_en_ff;                // heartbeat enable
    logic        multi_ff;                // multi-event enable
    logic [31:0] hb_timeout_ff;           // timeout in ms
    logic [31:0] msg_chan_ff;             // message channel number
    logic [63:0] ns_count_ff;             // free-running ns counter
    logic [63:0] time_ff;                 // captured time
    logic [31:0] ms_div_ff;               // clock cycles within a ms
    logic [31:0] hb_left_ff;              // ms left before expiry
    logic [31:0] rdata_ff;                // read data register
    logic        ms_tick;                 // one-cycle ms tick
    logic        host_access;             // any host access this cycle

    assign host_access = req.wr | req.rd;

    // ------------------------------------------------------------------
    // configuration register writes; unsupported bits stay at zero
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            hb_en_ff <= 1'b0;
            multi_ff <= 1'b0;
        end else if (clk_en && req.wr && hit(req.addr, OFS_DEV_CFG_LO)) begin
            hb_en_ff <= req.wdata[CFG_HB_ENABLE] & cap_priv;
            multi_ff <= req.wdata[CFG_MULTI_EVENT] & cap_multi;
        end
    end

    // ------------------------------------------------------------------
    // heartbeat timeout and message channel registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            hb_timeout_ff <= HB_TIMEOUT_RST;
            msg_chan_ff   <= MSG_CHANNEL_RST;
        end else if (clk_en && req.wr) begin
            if (hit(req.addr, OFS_HB_TIMEOUT) && cap_priv) begin
                hb_timeout_ff <= req.wdata;
            end else if (hit(req.addr, OFS_MSG_CHANNEL) && cap_msg) begin
                msg_chan_ff <= req.wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // nanosecond counter and capture; latch bit is never stored
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            ns_count_ff <= TIME_RST;
            time_ff     <= TIME_RST;
        end else if (clk_en) begin
            ns_count_ff <= ns_count_ff + NS_PER_CLK;
            if (cap_ts && req.wr && hit(req.addr, OFS_TIME_LATCH) && req.wdata[LATCH_BIT]) begin
                time_ff <= ns_count_ff;
            end
        end
    end

    // ------------------------------------------------------------------
    // millisecond tick divider
    // ------------------------------------------------------------------
    assign ms_tick = (ms_div_ff == 32'(MS_TICK - 1));
    always_ff @(posedge clock) begin
        if (!rstn) begin
            ms_div_ff <= ZERO32;
        end else if (clk_en) begin
            ms_div_ff <= ms_tick ? ZERO32 : ms_div_ff + 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // heartbeat countdown; a host access reloads, expiry fires once
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            hb_left_ff <= HB_TIMEOUT_RST;
            hb_expired <= 1'b0;
        end else if (clk_en) begin
            hb_expired <= 1'b0;
            if (!hb_en_ff || host_access) begin
                hb_left_ff <= hb_timeout_ff;
            end else if (ms_tick && hb_left_ff != ZERO32) begin
                hb_left_ff <= hb_left_ff - 32'h1;
                hb_expired <= (hb_left_ff == 32'h1);
            end
        end
    end

    // ------------------------------------------------------------------
    // expiry effects: link defaults and privilege release, one pulse
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            link_defaults <= 1'b0;
            priv_clear    <= 1'b0;
        end else if (clk_en) begin
            link_defaults <= hb_expired;
            priv_clear    <= hb_expired & cap_priv;
        end
    end

    // ------------------------------------------------------------------
    // pending ack: command running past half the advertised time.
    // half leaves margin for the ack packet to get out in time.
    // ------------------------------------------------------------------
    logic        cmd_busy_ff;             // command in execution
    logic [31:0] cmd_ms_ff;               // ms elapsed in command
    always_ff @(posedge clock) begin
        if (!rstn) begin
            cmd_busy_ff <= 1'b0;
            cmd_ms_ff   <= ZERO32;
            pending_ack <= 1'b0;
        end else if (clk_en) begin
            pending_ack <= 1'b0;
            if (cmd_start) begin
                cmd_busy_ff <= 1'b1;
                cmd_ms_ff   <= ZERO32;
            end else if (cmd_done) begin
                cmd_busy_ff <= 1'b0;
            end else if (cmd_busy_ff && ms_tick) begin
                if (cmd_ms_ff + 32'h1 >= (max_resp >> 1)) begin
                    pending_ack <= 1'b1;
                    cmd_ms_ff   <= ZERO32;
                end else begin
                    cmd_ms_ff <= cmd_ms_ff + 32'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // read path: data stands the cycle after the strobe; unmapped reads 0
    // ------------------------------------------------------------------
    logic [31:0] nxt_rdata;
    always_comb begin
        nxt_rdata = ZERO32;
        if (hit(req.addr, OFS_MAX_RESP_TIME)) begin
            nxt_rdata = max_resp;
        end else if (hit(req.addr, OFS_MANIFEST_LO)) begin
            nxt_rdata = MANIFEST_PTR[31:0];
        end else if (hit(req.addr, OFS_MANIFEST_HI)) begin
            nxt_rdata = MANIFEST_PTR[63:32];
        end else if (hit(req.addr, OFS_TECH_MAP_LO) && cap_tech) begin
            nxt_rdata = TECH_MAP_PTR[31:0];
        end else if (hit(req.addr, OFS_TECH_MAP_HI) && cap_tech) begin
            nxt_rdata = TECH_MAP_PTR[63:32];
        end else if (hit(req.addr, OFS_DEV_CFG_LO)) begin
            nxt_rdata = {30'h0, multi_ff, hb_en_ff};
        end else if (hit(req.addr, OFS_HB_TIMEOUT) && cap_priv) begin
            nxt_rdata = hb_timeout_ff;
        end else if (hit(req.addr, OFS_MSG_CHANNEL) && cap_msg) begin
            nxt_rdata = msg_chan_ff;
        end else if (hit(req.addr, OFS_TIME_LO) && cap_ts) begin
            nxt_rdata = time_ff[31:0];
        end else if (hit(req.addr, OFS_TIME_HI) && cap_ts) begin
            nxt_rdata = time_ff[63:32];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            rdata_ff <= ZERO32;
        end else if (clk_en) begin
            rdata_ff <= req.rd ? nxt_rdata : ZERO32;
        end
    end
    assign reg_rdata = rdata_ff;

    // ------------------------------------------------------------------
    // unit-side config outputs, registered
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            multi_event_en     <= 1'b0;
            msg_channel_number <= MSG_CHANNEL_RST;
            msg_allowed        <= 1'b0;
        end else if (clk_en) begin
            multi_event_en     <= multi_ff;
            msg_channel_number <= msg_chan_ff;
            msg_allowed        <= cap_msg && (msg_chan_ff != ZERO32);
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_resp_cap;
        @(posedge clock) disable iff (!rstn)
        (reg_rd && clk_en && reg_addr == OFS_MAX_RESP_TIME) |=> (reg_rdata <= MAX_RESP_LIMIT_MS);
    endproperty
    a_resp_cap: assert property (p_resp_cap) else $error("response time above cap");

    property p_rd_next;
        @(posedge clock) disable iff (!rstn)
        (reg_rd && clk_en && reg_addr == OFS_MAX_RESP_TIME) |=> (reg_rdata == $past(max_resp));
    endproperty
    a_rd_next: assert property (p_rd_next) else $error("response time read wrong");

    property p_cfg_zero;
        @(posedge clock) disable iff (!rstn)
        (!cap_priv |-> !hb_en_ff) and (!cap_multi |-> !multi_ff);
    endproperty
    a_cfg_zero: assert property (p_cfg_zero) else $error("unsupported config bit set");

    property p_reload;
        @(posedge clock) disable iff (!rstn)
        (clk_en && host_access && hb_en_ff) |=> (hb_left_ff == $past(hb_timeout_ff));
    endproperty
    a_reload: assert property (p_reload) else $error("heartbeat not reloaded");

    property p_no_expire_off;
        @(posedge clock) disable iff (!rstn)
        (!hb_en_ff && clk_en) |=> !hb_expired;
    endproperty
    a_no_expire_off: assert property (p_no_expire_off) else $error("expiry while disabled");

    property p_expiry_fx;
        @(posedge clock) disable iff (!rstn)
        (hb_expired && clk_en) |=> (link_defaults && (priv_clear == $past(cap_priv)));
    endproperty
    a_expiry_fx: assert property (p_expiry_fx) else $error("expiry effects missing");

    property p_msg_zero;
        @(posedge clock) disable iff (!rstn)
        msg_allowed |-> (msg_channel_number != ZERO32);
    endproperty
    a_msg_zero: assert property (p_msg_zero) else $error("messages on channel zero");

    property p_latch;
        @(posedge clock) disable iff (!rstn)
        (clk_en && cap_ts && reg_wr && reg_addr == OFS_TIME_LATCH && reg_wdata[LATCH_BIT])
            |=> (time_ff == $past(ns_count_ff));
    endproperty
    a_latch: assert property (p_latch) else $error("time not captured");

    // ------------------------------------------------------------------
    // checks: read data, pending ack, expiry pulse, capture, freeze
    // ------------------------------------------------------------------
    // read data is zero after any clock-enabled cycle without a read, so a stale
    // word can never be mistaken for a fresh answer
    property p_rd_idle;
        @(posedge clock) disable iff (!rstn)
        (clk_en && !reg_rd) |=> (reg_rdata == ZERO32);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");

    // a pending ack is only asked for on behalf of a running command
    property p_pend_busy;
        @(posedge clock) disable iff (!rstn)
        pending_ack |-> cmd_busy_ff;
    endproperty
    a_pend_busy: assert property (p_pend_busy) else $error("pending ack while idle");

    // expiry is a single pulse; the countdown rests at zero afterwards
    property p_hb_once;
        @(posedge clock) disable iff (!rstn)
        (hb_expired && clk_en) |=> !hb_expired;
    endproperty
    a_hb_once: assert property (p_hb_once) else $error("expiry repeated");

    // captured time moves only on a latch write, never on its own
    property p_time_hold;
        @(posedge clock) disable iff (!rstn)
        (clk_en && !(reg_wr && reg_addr == OFS_TIME_LATCH)) |=> $stable(time_ff);
    endproperty
    a_time_hold: assert property (p_time_hold) else $error("time changed without latch");

    // the unit sees the channel word one cycle after it is stored
    property p_chan_out;
        @(posedge clock) disable iff (!rstn)
        clk_en |=> (msg_channel_number == $past(msg_chan_ff));
    endproperty
    a_chan_out: assert property (p_chan_out) else $error("channel output lags");

    // clock enable low freezes the counters and the host-written words
    property p_freeze;
        @(posedge clock) disable iff (!rstn)
        !clk_en |=> ($stable(ns_count_ff) && $stable(hb_left_ff) && $stable(msg_chan_ff));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

endmodule // bcr_regs

`default_nettype wire
